// file: core/core_sfr_pkg.sv
package core_sfr_pkg;

	// File addresses
	localparam logic [4:0] ADDR_INDIRECT_WINDOW = 5'h00;
	localparam logic [4:0] ADDR_TIMER0_COUNT = 5'h01;
	localparam logic [4:0] ADDR_PROGRAM_COUNTER_LOW = 5'h02;
	localparam logic [4:0] ADDR_ALU_RESET_PAGE_WORD = 5'h03;
	localparam logic [4:0] ADDR_INDIRECT_POINTER = 5'h04;
	localparam logic [4:0] ADDR_PORT_A_LATCH = 5'h05;
	localparam logic [4:0] ADDR_PORT_B_LATCH = 5'h06;
	localparam logic [4:0] ADDR_PORT_C_LATCH = 5'h07;
	localparam logic [4:0] ADDR_GP_FIRST = 5'h08;

	// Status word field positions
	localparam int STAT_PAGE_HI = 7;
	localparam int STAT_PAGE_LO = 5;
	localparam int STAT_TIMEOUT = 4;
	localparam int STAT_POWER_DOWN = 3;
	localparam int STAT_ZERO = 2;
	localparam int STAT_DIGIT_CARRY = 1;
	localparam int STAT_CARRY = 0;

	// Flag update vector positions (same order as status low bits)
	localparam int UPD_ZERO = 2;
	localparam int UPD_DIGIT_CARRY = 1;
	localparam int UPD_CARRY = 0;

	// Reset values
	localparam logic [7:0] PCL_RESET = 8'hff;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [7:0] PTR_FORCE_LARGE = 8'h80;
	localparam logic [7:0] PTR_FORCE_SMALL = 8'he0;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [5:0] OPTION_RESET = 6'h3f;

	// Port A width and general purpose memory shape
	localparam int PORT_A_BITS = 4;
	localparam int GP_ADDR_BITS = 7;
	localparam int GP_DEPTH = 128;

	// Pin direction register select
	localparam logic [1:0] DIR_SEL_A = 2'h0;
	localparam logic [1:0] DIR_SEL_B = 2'h1;
	localparam logic [1:0] DIR_SEL_C = 2'h2;

endpackage

// file: core/core_special_register_file.sv
// Notes on behaviour
// - Pointer at 04h; large variant top bit one
// - Only low PC byte at 02h, resets ones
// - Port A low four bits; upper read zero
// - 07h is port C only when present
// - Small variant: pointer top three bits ones
// - Status at 03h writable, fixed bit layout
// - Flag-updating op blocks data write to flags
// - Timeout and power-down flags are read-only
// - Clear of status: pages zero, zero set
// - Page preselect bits choose program page
// - 00h window reaches register pointed to
// - Zero flag follows result equal zero
// - Add sets digit carry from bit three
`timescale 1ns/1ps
module core_special_register_file
#(
	parameter bit P_LARGE_MEM = 1'b0,
	parameter bit P_HAS_PORT_C = 1'b0
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_soft_reset,
	// File register access
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [4:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic o_rvalid,
	output logic [7:0] o_rdata,
	// Flag update from the ALU
	input wire logic [2:0] i_flag_upd,
	input wire logic i_alu_is_add,
	input wire logic [7:0] i_alu_a,
	input wire logic [7:0] i_alu_b,
	input wire logic [7:0] i_alu_result,
	input wire logic i_alu_dc,
	input wire logic i_alu_c,
	// Reset cause flags
	input wire logic i_timeout_set,
	input wire logic i_timeout_clr,
	input wire logic i_power_down_set,
	input wire logic i_power_down_clr,
	// Program counter and timer
	input wire logic i_pc_load,
	input wire logic [7:0] i_pc_next,
	input wire logic i_timer_tick,
	output logic [7:0] o_program_counter_low,
	output logic [7:0] o_timer0_count,
	output logic [1:0] o_page_preselect,
	output logic o_page_bit_spare,
	output logic o_timeout_flag,
	output logic o_power_down_flag,
	// Ports, direction and option
	input wire logic [core_sfr_pkg::PORT_A_BITS-1:0] i_port_a_pin,
	input wire logic [7:0] i_port_b_pin,
	input wire logic [7:0] i_port_c_pin,
	input wire logic i_dir_we,
	input wire logic [1:0] i_dir_sel,
	input wire logic i_option_we,
	output logic [core_sfr_pkg::PORT_A_BITS-1:0] o_port_a_latch,
	output logic [7:0] o_port_b_latch,
	output logic [7:0] o_port_c_latch,
	output logic [7:0] o_dir_a,
	output logic [7:0] o_dir_b,
	output logic [7:0] o_dir_c,
	output logic [5:0] o_timer_prescale_config
);

	localparam logic [7:0] PTR_FORCE = P_LARGE_MEM ? core_sfr_pkg::PTR_FORCE_LARGE
		: core_sfr_pkg::PTR_FORCE_SMALL;

	typedef struct packed
	{
		logic [7:0] timer;
		logic [7:0] program_counter_low;
		logic [2:0] page;
		logic timeout;
		logic power_down;
		logic zero;
		logic dc;
		logic carry;
		logic [7:0] ptr;
		logic [core_sfr_pkg::PORT_A_BITS-1:0] pa;
		logic [7:0] pb;
		logic [7:0] pc;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
		logic [5:0] option;
		logic rd_pend;
		logic rd_gp;
		logic [7:0] rd_sfr;
		logic rvalid;
		logic [7:0] rdata;
	} sfr_state_t;

	sfr_state_t s_q;
	sfr_state_t s_d;

	logic [4:0] ea;
	logic [1:0] bank;
	logic is_gp;
	logic [core_sfr_pkg::GP_ADDR_BITS-1:0] gp_addr;
	logic [7:0] gp_rdata;
	logic [8:0] add_sum;
	logic [4:0] add_low;
	logic [7:0] status_word;

	// Indirect access resolves the pointer before decode
	always_comb
	begin
		ea = (i_addr == core_sfr_pkg::ADDR_INDIRECT_WINDOW) ? s_q.ptr[4:0] : i_addr;
		bank = (P_LARGE_MEM && ea[4]) ? s_q.ptr[6:5] : 2'h0;
		gp_addr = {bank, ea};
		is_gp = (ea >= core_sfr_pkg::ADDR_GP_FIRST)
			|| (ea == core_sfr_pkg::ADDR_PORT_C_LATCH && !P_HAS_PORT_C);
		add_sum = {1'b0, i_alu_a} + {1'b0, i_alu_b};
		add_low = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
		status_word = {s_q.page, s_q.timeout, s_q.power_down, s_q.zero, s_q.dc, s_q.carry};
	end

	gp_file_mem u_gp_mem
	(
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_we(i_wr_en && is_gp),
		.i_waddr(gp_addr),
		.i_wdata(i_wdata),
		.i_raddr(gp_addr),
		.o_rdata(gp_rdata)
	);

	always_comb
	begin
		s_d = s_q;
		if (i_timer_tick)
		begin
			s_d.timer = s_q.timer + 8'h01;
		end
		if (i_pc_load)
		begin
			s_d.program_counter_low = i_pc_next;
		end
		// Direct writes; a pointer aimed at the window itself writes nothing
		if (i_wr_en && !is_gp)
		begin
			unique case (ea)
				core_sfr_pkg::ADDR_TIMER0_COUNT: s_d.timer = i_wdata;
				core_sfr_pkg::ADDR_PROGRAM_COUNTER_LOW: s_d.program_counter_low = i_wdata;
				core_sfr_pkg::ADDR_ALU_RESET_PAGE_WORD:
				begin
					s_d.page = i_wdata[core_sfr_pkg::STAT_PAGE_HI:core_sfr_pkg::STAT_PAGE_LO];
					if (i_flag_upd == 3'h0)
					begin
						s_d.zero = i_wdata[core_sfr_pkg::STAT_ZERO];
						s_d.dc = i_wdata[core_sfr_pkg::STAT_DIGIT_CARRY];
						s_d.carry = i_wdata[core_sfr_pkg::STAT_CARRY];
					end
				end
				core_sfr_pkg::ADDR_INDIRECT_POINTER: s_d.ptr = i_wdata | PTR_FORCE;
				core_sfr_pkg::ADDR_PORT_A_LATCH:
					s_d.pa = i_wdata[core_sfr_pkg::PORT_A_BITS-1:0];
				core_sfr_pkg::ADDR_PORT_B_LATCH: s_d.pb = i_wdata;
				core_sfr_pkg::ADDR_PORT_C_LATCH: s_d.pc = i_wdata;
				default: ;
			endcase
		end
		// Result flags overrule any data written to them
		if (i_flag_upd[core_sfr_pkg::UPD_ZERO])
		begin
			s_d.zero = (i_alu_result == 8'h00);
		end
		if (i_flag_upd[core_sfr_pkg::UPD_DIGIT_CARRY])
		begin
			s_d.dc = i_alu_is_add ? add_low[4] : i_alu_dc;
		end
		if (i_flag_upd[core_sfr_pkg::UPD_CARRY])
		begin
			s_d.carry = i_alu_is_add ? add_sum[8] : i_alu_c;
		end
		// Only hardware events move these; set wins over clear
		if (i_timeout_clr)
		begin
			s_d.timeout = 1'b0;
		end
		if (i_timeout_set)
		begin
			s_d.timeout = 1'b1;
		end
		if (i_power_down_clr)
		begin
			s_d.power_down = 1'b0;
		end
		if (i_power_down_set)
		begin
			s_d.power_down = 1'b1;
		end
		if (i_dir_we)
		begin
			unique case (i_dir_sel)
				core_sfr_pkg::DIR_SEL_A: s_d.dir_a = i_wdata;
				core_sfr_pkg::DIR_SEL_B: s_d.dir_b = i_wdata;
				core_sfr_pkg::DIR_SEL_C: s_d.dir_c = i_wdata;
				default: ;
			endcase
		end
		if (i_option_we)
		begin
			s_d.option = i_wdata[5:0];
		end
		// Pin or watchdog reset: port latches and flags hold
		if (i_soft_reset)
		begin
			s_d.program_counter_low = core_sfr_pkg::PCL_RESET;
			s_d.page = core_sfr_pkg::PAGE_RESET;
			s_d.ptr = s_q.ptr | PTR_FORCE;
			s_d.dir_a = core_sfr_pkg::DIR_RESET;
			s_d.dir_b = core_sfr_pkg::DIR_RESET;
			s_d.dir_c = core_sfr_pkg::DIR_RESET;
			s_d.option = core_sfr_pkg::OPTION_RESET;
		end
		// Two-stage read: memory data are registered, so the mux waits a cycle
		s_d.rd_pend = i_rd_en;
		s_d.rd_gp = is_gp;
		unique case (ea)
			core_sfr_pkg::ADDR_TIMER0_COUNT: s_d.rd_sfr = s_q.timer;
			core_sfr_pkg::ADDR_PROGRAM_COUNTER_LOW: s_d.rd_sfr = s_q.program_counter_low;
			core_sfr_pkg::ADDR_ALU_RESET_PAGE_WORD: s_d.rd_sfr = status_word;
			core_sfr_pkg::ADDR_INDIRECT_POINTER: s_d.rd_sfr = s_q.ptr;
			core_sfr_pkg::ADDR_PORT_A_LATCH: s_d.rd_sfr = {4'h0, i_port_a_pin};
			core_sfr_pkg::ADDR_PORT_B_LATCH: s_d.rd_sfr = i_port_b_pin;
			core_sfr_pkg::ADDR_PORT_C_LATCH: s_d.rd_sfr = i_port_c_pin;
			default: s_d.rd_sfr = 8'h00;
		endcase
		s_d.rvalid = s_q.rd_pend;
		if (s_q.rd_pend)
		begin
			s_d.rdata = s_q.rd_gp ? gp_rdata : s_q.rd_sfr;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s_q <= '0;
			s_q.program_counter_low <= core_sfr_pkg::PCL_RESET;
			s_q.timeout <= 1'b1;
			s_q.power_down <= 1'b1;
			s_q.ptr <= PTR_FORCE;
			s_q.dir_a <= core_sfr_pkg::DIR_RESET;
			s_q.dir_b <= core_sfr_pkg::DIR_RESET;
			s_q.dir_c <= core_sfr_pkg::DIR_RESET;
			s_q.option <= core_sfr_pkg::OPTION_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign o_rvalid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_program_counter_low = s_q.program_counter_low;
	assign o_timer0_count = s_q.timer;
	// Upper page bit is spare; only the lower two steer jumps and calls
	assign o_page_preselect = s_q.page[1:0];
	assign o_page_bit_spare = s_q.page[2];
	assign o_timeout_flag = s_q.timeout;
	assign o_power_down_flag = s_q.power_down;
	assign o_port_a_latch = s_q.pa;
	assign o_port_b_latch = s_q.pb;
	assign o_port_c_latch = s_q.pc;
	assign o_dir_a = s_q.dir_a;
	assign o_dir_b = s_q.dir_b;
	assign o_dir_c = s_q.dir_c;
	assign o_timer_prescale_config = s_q.option;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	pointer_force_a: assert property ((s_q.ptr & PTR_FORCE) == PTR_FORCE)
		else $error("pointer forced bits not set");
	pcl_reset_a: assert property (i_soft_reset |=> o_program_counter_low == 8'hff)
		else $error("low PC byte not reset to ones");
	port_a_latch_read_a: assert property (i_rd_en && !is_gp
		&& ea == core_sfr_pkg::ADDR_PORT_A_LATCH |-> ##2 o_rvalid && o_rdata[7:4] == 4'h0)
		else $error("port A upper bits not zero");
	status_page_a: assert property (i_wr_en && !is_gp && !i_soft_reset
		&& ea == core_sfr_pkg::ADDR_ALU_RESET_PAGE_WORD
		|=> {o_page_bit_spare, o_page_preselect} == $past(i_wdata[7:5]))
		else $error("page bits not written");
	flag_block_a: assert property (i_wr_en && !is_gp && i_flag_upd == 3'h4
		&& ea == core_sfr_pkg::ADDR_ALU_RESET_PAGE_WORD |=> $stable({s_q.dc, s_q.carry}))
		else $error("blocked flags were written");
	timeout_ro_a: assert property (!i_timeout_set && !i_timeout_clr
		|=> o_timeout_flag == $past(o_timeout_flag))
		else $error("timeout flag moved without cause");
	zero_flag_a: assert property (i_flag_upd[core_sfr_pkg::UPD_ZERO]
		|=> s_q.zero == ($past(i_alu_result) == 8'h00))
		else $error("zero flag wrong");
	digit_carry_a: assert property (i_flag_upd[core_sfr_pkg::UPD_DIGIT_CARRY] && i_alu_is_add
		|=> s_q.dc == (($past({1'b0, i_alu_a[3:0]})
		+ $past({1'b0, i_alu_b[3:0]})) > 5'h0f))
		else $error("digit carry wrong");
	read_latency_a: assert property (i_rd_en |-> ##2 o_rvalid)
		else $error("read answer not two cycles later");
	dir_reset_a: assert property (i_soft_reset && !i_dir_we |=> o_dir_a == 8'hff
		&& o_dir_b == 8'hff && o_timer_prescale_config == 6'h3f)
		else $error("direction or option not reset");

	indirect_read_c: cover property (i_rd_en && i_addr == core_sfr_pkg::ADDR_INDIRECT_WINDOW
		&& is_gp ##2 o_rvalid);
	status_clear_c: cover property (i_wr_en && ea == core_sfr_pkg::ADDR_ALU_RESET_PAGE_WORD
		&& i_wdata == 8'h00 && i_flag_upd == 3'h4);
	add_carry_c: cover property (i_flag_upd == 3'h7 && i_alu_is_add && add_sum[8]);

endmodule

// file: core/gp_file_mem.sv
`timescale 1ns/1ps
module gp_file_mem
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Write port
	input wire logic i_we,
	input wire logic [core_sfr_pkg::GP_ADDR_BITS-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// Read port, data one cycle later
	input wire logic [core_sfr_pkg::GP_ADDR_BITS-1:0] i_raddr,
	output logic [7:0] o_rdata
);

	typedef struct packed
	{
		logic [core_sfr_pkg::GP_DEPTH-1:0][7:0] cells;
		logic [7:0] rdata;
	} mem_state_t;

	mem_state_t s_q;
	mem_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.rdata = s_q.cells[i_raddr];
		if (i_we)
		begin
			s_d.cells[i_waddr] = i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;

endmodule

// file: verif/exec_core_model.sv
`timescale 1ns/1ps
module exec_core_model
(
	// Clock
	input wire logic i_ref_clk,
	// File bus
	output logic o_rd_en,
	output logic o_wr_en,
	output logic [4:0] o_addr,
	output logic [7:0] o_wdata,
	// Flag update
	output logic [2:0] o_flag_upd,
	output logic [7:0] o_alu_result
);
	initial
	begin
		{o_rd_en, o_wr_en, o_addr, o_wdata, o_flag_upd, o_alu_result} = '0;
	end

	// One edge per access; data then shows the inverse so stale data never looks valid
	// Status flags are altered by plain moves unless a flag update is asked; page bits always are
	task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data,
		input logic [2:0] upd, input logic [7:0] res);
		@(posedge i_ref_clk);
		o_rd_en <= ~wr;
		o_wr_en <= wr;
		o_addr <= addr;
		o_wdata <= data;
		o_flag_upd <= upd;
		o_alu_result <= res;
		@(posedge i_ref_clk);
		{o_rd_en, o_wr_en, o_flag_upd} <= '0;
		o_wdata <= ~data;
		o_alu_result <= ~res;
	endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic ref_clk;
	logic resetn;
	logic soft_reset, rd_en, wr_en, rvalid, is_add, alu_dc, alu_c;
	logic tset, tclr, pset, pclr, tick, spare, tflag, pflag;
	logic pc_load, dir_we, opt_we;
	logic [1:0] page, dir_sel;
	logic [2:0] upd;
	logic [3:0] pin_a, latch_a;
	logic [4:0] addr;
	logic [5:0] opt;
	logic [7:0] wdata, rdata, alu_a, alu_b, res, pin_b, pin_c, dir_a, dir_b, dir_c, v;
	logic [7:0] pc_next, program_counter_low, tmr, latch_b, latch_c;
	int failures = 0;
	int samples_checked = 0;
	integer seed = 32'h8eb5;
	logic [7:0] expq[$];

	exec_core_model core (.i_ref_clk(ref_clk), .o_rd_en(rd_en), .o_wr_en(wr_en),
		.o_addr(addr), .o_wdata(wdata), .o_flag_upd(upd), .o_alu_result(res));

	core_special_register_file dut (.i_ref_clk(ref_clk), .i_resetn(resetn),
		.i_soft_reset(soft_reset), .i_rd_en(rd_en), .i_wr_en(wr_en), .i_addr(addr),
		.i_wdata(wdata), .o_rvalid(rvalid), .o_rdata(rdata), .i_flag_upd(upd),
		.i_alu_is_add(is_add), .i_alu_a(alu_a), .i_alu_b(alu_b), .i_alu_result(res),
		.i_alu_dc(alu_dc), .i_alu_c(alu_c), .i_timeout_set(tset), .i_timeout_clr(tclr),
		.i_power_down_set(pset), .i_power_down_clr(pclr), .i_pc_load(pc_load),
		.i_pc_next(pc_next), .i_timer_tick(tick), .o_program_counter_low(program_counter_low),
		.o_timer0_count(tmr), .o_page_preselect(page), .o_page_bit_spare(spare),
		.o_timeout_flag(tflag), .o_power_down_flag(pflag), .i_port_a_pin(pin_a),
		.i_port_b_pin(pin_b), .i_port_c_pin(pin_c), .i_dir_we(dir_we), .i_dir_sel(dir_sel),
		.i_option_we(opt_we), .o_port_a_latch(latch_a), .o_port_b_latch(latch_b),
		.o_port_c_latch(latch_c), .o_dir_a(dir_a), .o_dir_b(dir_b), .o_dir_c(dir_c),
		.o_timer_prescale_config(opt));

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [2:0] u = 3'h0,
		input logic [7:0] r = 8'h00);
		core.access(1'b1, a, d, u, r);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		expq.push_back(exp);
		core.access(1'b0, a, 8'h00, 3'h0, 8'h00);
	endtask

	task automatic conclude();
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read answers arrive in request order, so the oldest note is the one due
	always @(posedge ref_clk)
		if (rvalid === 1'b1)
		begin
			if (expq.size() == 0)
				check("rvalid_unexpected", 8'h00, 8'hff);
			else
				check("rdata", expq.pop_front(), rdata);
		end

	initial
	begin
		{soft_reset, is_add, alu_dc, alu_c, tset, tclr, pset, pclr, tick, alu_a, alu_b} = '0;
		{pc_load, dir_we, opt_we, dir_sel, pc_next} = '0;
		{pin_a, pin_b, pin_c} = 20'($random(seed));
		v = 8'($random(seed));
		resetn = 1'b0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(5'h02, 8'hff);
		rd(5'h03, 8'h18);
		rd(5'h04, 8'he0);
		check("dir_a", 8'hff, dir_a);
		check("dir_b", 8'hff, dir_b);
		check("dir_c", 8'hff, dir_c);
		check("option", 8'h3f, {2'h0, opt});
		wr(5'h03, 8'h00);
		rd(5'h03, 8'h18);
		wr(5'h03, 8'ha5);
		rd(5'h03, 8'hbd);
		check("page", 8'h05, {5'h00, spare, page});
		wr(5'h03, 8'he3);
		rd(5'h03, 8'hfb);
		wr(5'h03, 8'h00, 3'h4, 8'h00);
		rd(5'h03, 8'h1f);
		{is_add, alu_a, alu_b} <= {1'b1, 8'h0f, 8'h01};
		wr(5'h08, v, 3'h6, 8'h10);
		rd(5'h03, 8'h1b);
		{is_add, alu_dc, alu_c} <= 3'b010;
		wr(5'h03, 8'hff, 3'h3, 8'h10);
		rd(5'h03, 8'hfa);
		rd(5'h08, v);
		wr(5'h04, 8'h09);
		rd(5'h04, 8'he9);
		wr(5'h00, ~v);
		rd(5'h09, ~v);
		rd(5'h00, ~v);
		rd(5'h05, {4'h0, pin_a});
		wr(5'h05, v);
		wr(5'h06, ~v);
		// Latches update on the write edge, so look one edge later
		@(posedge ref_clk);
		check("port_a_latch", {4'h0, v[3:0]}, {4'h0, latch_a});
		check("port_b_latch", ~v, latch_b);
		rd(5'h06, pin_b);
		wr(5'h07, 8'h5c);
		rd(5'h07, 8'h5c);
		check("port_c_latch", 8'h00, latch_c);
		tick <= 1'b1;
		repeat (3) @(posedge ref_clk);
		tick <= 1'b0;
		rd(5'h01, 8'h03);
		check("timer0_count", 8'h03, tmr);
		{tclr, pclr} <= 2'b11;
		@(posedge ref_clk);
		{tclr, pclr} <= 2'b00;
		@(posedge ref_clk);
		check("reset_flags", 8'h00, {6'h00, tflag, pflag});
		wr(5'h03, 8'h18);
		rd(5'h03, 8'h00);
		{tset, pset} <= 2'b11;
		@(posedge ref_clk);
		{tset, pset} <= 2'b00;
		wr(5'h03, 8'he0);
		rd(5'h03, 8'hf8);
		wr(5'h02, 8'h3c);
		rd(5'h02, 8'h3c);
		{pc_load, pc_next} <= {1'b1, v};
		@(posedge ref_clk);
		pc_load <= 1'b0;
		@(posedge ref_clk);
		check("pcl", v, program_counter_low);
		// Write data is left at the inverse of the last written byte: 8'ha5
		wr(5'h1f, 8'h5a);
		{dir_we, dir_sel, opt_we} <= {1'b1, 2'h0, 1'b1};
		@(posedge ref_clk);
		{dir_we, dir_sel, opt_we} <= {1'b1, 2'h1, 1'b0};
		@(posedge ref_clk);
		dir_sel <= 2'h2;
		@(posedge ref_clk);
		dir_sel <= 2'h3;
		@(posedge ref_clk);
		dir_we <= 1'b0;
		@(posedge ref_clk);
		check("dir_a", 8'ha5, dir_a);
		check("dir_b", 8'ha5, dir_b);
		check("dir_c", 8'ha5, dir_c);
		check("option", 8'h25, {2'h0, opt});
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		rd(5'h02, 8'hff);
		rd(5'h04, 8'he9);
		rd(5'h03, 8'h18);
		check("pcl", 8'hff, program_counter_low);
		check("dir_a", 8'hff, dir_a);
		check("dir_b", 8'hff, dir_b);
		check("dir_c", 8'hff, dir_c);
		check("option", 8'h3f, {2'h0, opt});
		for (int i = 0; i < 8 && expq.size() > 0; i++)
			@(posedge ref_clk);
		check("pending_reads", 8'h00, 8'(expq.size()));
		conclude();
	end
endmodule
